// *** common/iso_rx_pkg.sv ***
/*
  Shared constants for the isochronous receive context block: register map,
  control-word field positions, speed and event encodings, context states.
  Assumes a 12-bit byte address space seen over APB with 32-bit data.
*/
package iso_rx_pkg;

  // context geometry
  localparam int NUM_CTX = 4;
  localparam int CTX_IDX_W = 2;

  // register map (byte addresses)
  localparam logic [11:0] CTX_SET_BASE = 12'h400;
  localparam logic [11:0] CTX_CLR_BASE = 12'h404;
  localparam logic [11:0] CTX_STRIDE = 12'h020;
  localparam logic [11:0] CTX_END = 12'h480;
  localparam logic [11:0] INT_STATUS_ADDR = 12'h480;
  localparam logic [11:0] INT_CLEAR_ADDR = 12'h484;
  localparam logic [11:0] INT_ENABLE_ADDR = 12'h488;

  // control word field positions
  localparam int FILL_BIT = 31;
  localparam int RUN_BIT = 15;
  localparam int WAKE_BIT = 12;
  localparam int DEAD_BIT = 11;
  localparam int ACTIVE_BIT = 10;
  localparam int BETA_BIT = 9;
  localparam int SPD_LSB = 5;
  localparam int EVT_LSB = 0;

  // reset values
  localparam logic [4:0] EVT_RESET = 5'h00;
  localparam logic [2:0] SPD_RESET = 3'h0;

  // receive speed codes
  localparam logic [2:0] SPD_S100 = 3'h0;
  localparam logic [2:0] SPD_S200 = 3'h1;
  localparam logic [2:0] SPD_S400 = 3'h2;
  localparam logic [2:0] SPD_S800 = 3'h3;

  // completion event codes
  localparam logic [4:0] EVT_LONG_PACKET = 5'h02;
  localparam logic [4:0] EVT_OVERRUN = 5'h05;
  localparam logic [4:0] EVT_DESC_READ = 5'h06;
  localparam logic [4:0] EVT_DATA_WRITE = 5'h08;
  localparam logic [4:0] EVT_UNKNOWN = 5'h0E;
  localparam logic [4:0] ACK_COMPLETE = 5'h11;
  localparam logic [4:0] ACK_DATA_ERROR = 5'h1D;

  // interrupt status layout: done, backout, dead groups of NUM_CTX bits
  localparam int IRQ_W = 3 * NUM_CTX;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_RECV = 2'b11,
    ST_STALL = 2'b10
  } ctx_state_e;

endpackage

// *** logic/irq_status.sv ***
/*
  Sticky interrupt status with write-one-to-clear and an enable mask.
  Assumes events are one-cycle pulses on clk_sys; clear is a one-cycle write.
*/
`timescale 1ns/1ps
module irq_status #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // event sources
  input wire logic [W-1:0] evt_in,
  // software side
  input wire logic [W-1:0] clr_mask,
  input wire logic en_wr,
  input wire logic [W-1:0] en_data,
  output logic [W-1:0] status_reg,
  output logic [W-1:0] enable_reg,
  output logic irq
);

  // a new event beats a clear in the same cycle so nothing is lost
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~clr_mask) | evt_in;
    end
  end

  // enable mask
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enable_reg <= '0;
    end else if (en_wr) begin
      enable_reg <= en_data;
    end
  end

  assign irq = |(status_reg & enable_reg);

endmodule

// *** logic/iso_rx_ctx.sv ***
/*
  One isochronous receive context: run/wake/fill control, dead/active
  state, descriptor sequencing and per-packet status writeback.
  Assumes descriptor fetch and packet reports come from clk_sys logic.
*/
`timescale 1ns/1ps
module iso_rx_ctx
  import iso_rx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // software strobes
  input wire logic run_set,
  input wire logic run_clr,
  input wire logic wake_set,
  input wire logic fill_set,
  input wire logic fill_clr,
  // control and status
  output logic run_reg,
  output logic wake_reg,
  output logic dead_reg,
  output logic active,
  output logic fill_reg,
  output logic beta_reg,
  output logic [2:0] spd_reg,
  output logic [4:0] evt_reg,
  // descriptor fetch
  output logic fetch_req,
  input wire logic fetch_ack,
  input wire logic fetch_valid,
  input wire logic fetch_err,
  // packet report
  input wire logic pkt_valid,
  input wire logic pkt_beta,
  input wire logic [2:0] pkt_spd,
  input wire logic pkt_len_err,
  input wire logic pkt_crc_err,
  input wire logic pkt_overrun,
  input wire logic pkt_long,
  input wire logic pkt_wr_err,
  input wire logic pkt_unknown,
  input wire logic pkt_buf_full,
  // events
  output logic done_reg,
  output logic backout_reg,
  output logic dead_evt_reg
);

  ctx_state_e state_reg, state_next;
  logic fetch_take, pkt_in, pkt_bad, pkt_fatal, fatal_now, drop;

  assign fetch_req = (state_reg == ST_FETCH);
  assign fetch_take = fetch_req && fetch_ack;
  assign pkt_in = (state_reg == ST_RECV) && pkt_valid;
  assign pkt_bad = pkt_len_err || pkt_crc_err || pkt_overrun;
  assign pkt_fatal = pkt_wr_err || pkt_unknown;
  assign fatal_now = (fetch_take && fetch_err) || (pkt_in && pkt_fatal);
  assign drop = pkt_in && fill_reg && pkt_bad && !pkt_fatal;
  assign active = (state_reg != ST_IDLE);

  // descriptor sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (run_reg && !dead_reg) state_next = ST_FETCH;
      ST_FETCH: begin
        if (fetch_ack) begin
          state_next = fetch_err ? ST_IDLE : (fetch_valid ? ST_RECV : ST_STALL);
        end
      end
      ST_STALL: if (wake_reg) state_next = ST_FETCH;
      ST_RECV: begin
        if (pkt_valid) begin
          if (pkt_fatal) begin
            state_next = ST_IDLE;
          end else if (!fill_reg || (!pkt_bad && pkt_buf_full)) begin
            state_next = ST_FETCH;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (!run_reg) state_next = ST_IDLE;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // run only moves on software strobes or reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) run_reg <= 1'b0;
    else if (run_set) run_reg <= 1'b1;
    else if (run_clr) run_reg <= 1'b0;
  end

  // software set beats the fetch clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) wake_reg <= 1'b0;
    else if (wake_set) wake_reg <= 1'b1;
    else if (fetch_take) wake_reg <= 1'b0;
  end

  // dead set by fatal error, cleared by run going low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) dead_reg <= 1'b0;
    else if (fatal_now) dead_reg <= 1'b1;
    else if (run_clr && run_reg) dead_reg <= 1'b0;
  end

  // fill option frozen while the context runs, avoids mid-buffer mode flips
  always_ff @(posedge clk_sys) begin
    if (sys_rst) fill_reg <= 1'b0;
    else if (!run_reg && !active && fill_set) fill_reg <= 1'b1;
    else if (!run_reg && !active && fill_clr) fill_reg <= 1'b0;
  end

  // status writeback, skipped for backed-out packets
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      evt_reg <= EVT_RESET;
      beta_reg <= 1'b0;
      spd_reg <= SPD_RESET;
    end else if (fetch_take && fetch_err) begin
      evt_reg <= EVT_DESC_READ;
    end else if (pkt_in && !drop) begin
      beta_reg <= pkt_beta;
      spd_reg <= pkt_spd;
      if (pkt_wr_err) evt_reg <= EVT_DATA_WRITE;
      else if (pkt_unknown) evt_reg <= EVT_UNKNOWN;
      else if (fill_reg) evt_reg <= ACK_COMPLETE;
      else if (pkt_overrun) evt_reg <= EVT_OVERRUN;
      else if (pkt_long) evt_reg <= EVT_LONG_PACKET;
      else if (pkt_len_err || pkt_crc_err) evt_reg <= ACK_DATA_ERROR;
      else evt_reg <= ACK_COMPLETE;
    end
  end

  // event pulses
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
      backout_reg <= 1'b0;
      dead_evt_reg <= 1'b0;
    end else begin
      done_reg <= pkt_in && !drop && !pkt_fatal;
      backout_reg <= drop;
      dead_evt_reg <= fatal_now;
    end
  end

  sequence run_start_s;
    run_set && !run_reg && !dead_reg && !fatal_now;
  endsequence

  wake_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fetch_take && !wake_set |=> !wake_reg)
    else $error("wake not cleared on descriptor fetch");
  dead_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fatal_now |=> dead_reg && dead_evt_reg)
    else $error("dead not set after fatal error");
  dead_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    run_clr && run_reg && !fatal_now |=> !dead_reg && !run_reg)
    else $error("dead not cleared with run");
  run_start_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    run_start_s ##1 !run_clr |=> active && fetch_req)
    else $error("context not active two cycles after run");
  backout_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    drop |=> backout_reg && $stable(evt_reg) && !done_reg)
    else $error("bad packet not backed out in fill mode");
  fill_code_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fill_reg && done_reg |-> evt_reg == ACK_COMPLETE)
    else $error("fill mode completion code wrong");

endmodule

// *** logic/iso_rx_ctrl.sv ***
/*
  Isochronous receive context control and status for four contexts, with
  an APB register slave and a level interrupt.
  Assumes descriptor fetch and receive-path reports come from logic on
  clk_sys; APB master follows the usual setup/access protocol.
*/
// Decided for this implementation: the register offsets and register access over APB.
// Notes on behaviour
// - hardware changes run only on reset
// - bits 14 and 13 read as zero
// - every descriptor fetch clears wake; here a software wake set in the fetch cycle wins and wake stays set
// - fatal error sets dead
// - clearing run clears dead
// - active high while processing descriptors
// - beta flag follows phy beta indication
// - responses to beta requests go in beta
// - bit 8 reads as zero
// - speed code 0..3 for 100..800 Mbit/s
// - fill mode reports four event codes only
// - fill mode backs out bad packets
// - per-buffer mode reports seven event codes
// - set and clear addresses, 32-byte stride, four contexts
// - fill packs packets, otherwise one per buffer
`timescale 1ns/1ps
module iso_rx_ctrl
  import iso_rx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // descriptor fetch, one request per context
  output logic [NUM_CTX-1:0] fetch_req,
  input wire logic [NUM_CTX-1:0] fetch_ack,
  input wire logic fetch_valid,
  input wire logic fetch_err,
  // receive path packet report
  input wire logic pkt_valid,
  input wire logic [CTX_IDX_W-1:0] pkt_ctx,
  input wire logic pkt_beta,
  input wire logic [2:0] pkt_spd,
  input wire logic pkt_len_err,
  input wire logic pkt_crc_err,
  input wire logic pkt_overrun,
  input wire logic pkt_long,
  input wire logic pkt_wr_err,
  input wire logic pkt_unknown,
  input wire logic pkt_buf_full,
  // receive path feedback
  output logic [NUM_CTX-1:0] backout,
  output logic [NUM_CTX-1:0] rsp_beta
);

  // address classification shared by read and write paths
  function automatic logic is_ctx(input logic [11:0] a);
    return (a >= CTX_SET_BASE) && (a < CTX_END) && (a[4:0] == CTX_SET_BASE[4:0] ||
      a[4:0] == CTX_CLR_BASE[4:0]);
  endfunction

  function automatic logic is_clr(input logic [11:0] a);
    return a[4:0] == CTX_CLR_BASE[4:0];
  endfunction

  function automatic logic [CTX_IDX_W-1:0] ctx_of(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - CTX_SET_BASE;
    return rel[5 +: CTX_IDX_W];
  endfunction

  logic wr_acc, rd_setup, hit;
  logic [NUM_CTX-1:0] run_set, run_clr, wake_set, fill_set, fill_clr;
  logic [NUM_CTX-1:0] run_v, wake_v, dead_v, active_v, fill_v, beta_v;
  logic [NUM_CTX-1:0] done_v, dead_evt_v;
  logic [2:0] spd_v [NUM_CTX];
  logic [4:0] evt_v [NUM_CTX];
  logic [31:0] ctl_word [NUM_CTX];
  logic [IRQ_W-1:0] irq_stat, irq_en, irq_clr;
  logic [31:0] rdata_next;

  // zero wait states: setup cycle samples read data, access completes
  assign pready = 1'b1;
  assign hit = is_ctx(paddr) || paddr == INT_STATUS_ADDR || paddr == INT_CLEAR_ADDR ||
    paddr == INT_ENABLE_ADDR;
  assign pslverr = psel && penable && !hit;
  assign wr_acc = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;

  // set and clear address strobes per context
  always_comb begin
    run_set = '0;
    run_clr = '0;
    wake_set = '0;
    fill_set = '0;
    fill_clr = '0;
    if (wr_acc && is_ctx(paddr)) begin
      if (is_clr(paddr)) begin
        run_clr[ctx_of(paddr)] = pwdata[RUN_BIT];
        fill_clr[ctx_of(paddr)] = pwdata[FILL_BIT];
      end else begin
        run_set[ctx_of(paddr)] = pwdata[RUN_BIT];
        wake_set[ctx_of(paddr)] = pwdata[WAKE_BIT];
        fill_set[ctx_of(paddr)] = pwdata[FILL_BIT];
      end
    end
  end

  // one engine per context; packet report steered by context number
  for (genvar i = 0; i < NUM_CTX; i++) begin : g_ctx
    logic sel;
    assign sel = pkt_valid && (pkt_ctx == CTX_IDX_W'(i));

    iso_rx_ctx u_ctx (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .run_set(run_set[i]),
      .run_clr(run_clr[i]),
      .wake_set(wake_set[i]),
      .fill_set(fill_set[i]),
      .fill_clr(fill_clr[i]),
      .run_reg(run_v[i]),
      .wake_reg(wake_v[i]),
      .dead_reg(dead_v[i]),
      .active(active_v[i]),
      .fill_reg(fill_v[i]),
      .beta_reg(beta_v[i]),
      .spd_reg(spd_v[i]),
      .evt_reg(evt_v[i]),
      .fetch_req(fetch_req[i]),
      .fetch_ack(fetch_ack[i]),
      .fetch_valid(fetch_valid),
      .fetch_err(fetch_err),
      .pkt_valid(sel),
      .pkt_beta(pkt_beta),
      .pkt_spd(pkt_spd),
      .pkt_len_err(pkt_len_err),
      .pkt_crc_err(pkt_crc_err),
      .pkt_overrun(pkt_overrun),
      .pkt_long(pkt_long),
      .pkt_wr_err(pkt_wr_err),
      .pkt_unknown(pkt_unknown),
      .pkt_buf_full(pkt_buf_full),
      .done_reg(done_v[i]),
      .backout_reg(backout[i]),
      .dead_evt_reg(dead_evt_v[i])
    );

    // control word image; unimplemented mode and reserved bits read zero
    always_comb begin
      ctl_word[i] = 32'h0000_0000;
      ctl_word[i][FILL_BIT] = fill_v[i];
      ctl_word[i][RUN_BIT] = run_v[i]; // bits 14:13 stay zero
      ctl_word[i][WAKE_BIT] = wake_v[i];
      ctl_word[i][DEAD_BIT] = dead_v[i];
      ctl_word[i][ACTIVE_BIT] = active_v[i];
      ctl_word[i][BETA_BIT] = beta_v[i]; // bit 8 stays zero
      ctl_word[i][SPD_LSB +: 3] = spd_v[i];
      ctl_word[i][EVT_LSB +: 5] = evt_v[i];
    end
  end

  // transmit side answers a beta-format request in beta format
  assign rsp_beta = beta_v;

  // interrupt: done, backout and dead events per context
  assign irq_clr = (wr_acc && paddr == INT_CLEAR_ADDR) ? pwdata[IRQ_W-1:0] : '0;

  irq_status #(
    .W(IRQ_W)
  ) u_irq (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .evt_in({dead_evt_v, backout, done_v}),
    .clr_mask(irq_clr),
    .en_wr(wr_acc && paddr == INT_ENABLE_ADDR),
    .en_data(pwdata[IRQ_W-1:0]),
    .status_reg(irq_stat),
    .enable_reg(irq_en),
    .irq(irq)
  );

  // read mux; clear address reads the same word as set address
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (is_ctx(paddr)) begin
      rdata_next = ctl_word[ctx_of(paddr)];
    end else if (paddr == INT_STATUS_ADDR) begin
      rdata_next[IRQ_W-1:0] = irq_stat;
    end else if (paddr == INT_ENABLE_ADDR) begin
      rdata_next[IRQ_W-1:0] = irq_en;
    end
  end

  // read data captured in setup so it is stable through the access cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) prdata <= 32'h0000_0000;
    else if (rd_setup) prdata <= rdata_next;
  end

  rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    psel && penable && !pwrite && is_ctx(paddr) |-> prdata[14:13] == 2'b00 &&
      prdata[26:16] == 11'h000)
    else $error("reserved control bits read nonzero");
  rsvd_bit8_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    psel && penable && !pwrite && is_ctx(paddr) |-> !prdata[8])
    else $error("reserved bit 8 read nonzero");
  run_stable_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(wr_acc && is_ctx(paddr)) |=> run_v == $past(run_v))
    else $error("run changed without a software write");
  // per-context status checks, so whichever context runs is covered
  for (genvar j = 0; j < NUM_CTX; j++) begin : g_chk
    speed_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      done_v[j] |-> spd_v[j] == $past(pkt_spd))
      else $error("speed code not taken from packet");
    ppb_code_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      done_v[j] && !fill_v[j] && $past(pkt_overrun) |-> evt_v[j] == EVT_OVERRUN)
      else $error("overrun code missing in per-buffer mode");
  end

  // a status bit only drops through a write-one-to-clear
  irq_sticky_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    1'b1 |=> (irq_stat & $past(irq_stat & ~irq_clr)) == $past(irq_stat & ~irq_clr))
    else $error("interrupt status bit lost without a clear");

endmodule

// *** verif/rx_partner.sv ***
/*
  Descriptor fetch responder standing in for host descriptor memory.
  Assumes the bench picks the answer kind through mode and slow.
*/
`timescale 1ns/1ps
module rx_partner
  import iso_rx_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // answer kind: 0 descriptor, 1 read error, 2 no descriptor
  input wire logic [1:0] mode,
  input wire logic slow,
  // descriptor fetch
  input wire logic [NUM_CTX-1:0] fetch_req,
  output logic [NUM_CTX-1:0] fetch_ack,
  output logic fetch_valid,
  output logic fetch_err
);
  int wait_cnt = 0;
  initial begin
    fetch_ack = '0;
    fetch_valid = 1'b0;
    fetch_err = 1'b0;
  end
  // one answer at a time; qualifiers churn when no answer is given
  always @(posedge clk_sys) begin
    fetch_ack <= '0;
    fetch_valid <= ~fetch_valid;
    fetch_err <= fetch_valid;
    if (fetch_ack == '0 && fetch_req != '0 && wait_cnt >= (slow ? 3 : 0)) begin
      fetch_ack <= fetch_req & (~fetch_req + 4'h1);
      fetch_valid <= (mode == 2'h0);
      fetch_err <= (mode == 2'h1);
      wait_cnt <= 0;
    end else begin
      wait_cnt <= (fetch_req != '0) ? wait_cnt + 1 : 0;
    end
  end
endmodule

// *** verif/tb.sv ***
/*
  Self-checking bench for iso_rx_ctrl: APB master, packet driver, queue
  of expected reads. Assumes zero-wait APB and a prompt or slow partner.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb
  import iso_rx_pkg::*;
;
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, irq, fetch_valid, fetch_err, pkt_valid = 0, pkt_beta = 0, slow = 0;
  logic [3:0] fetch_req, fetch_ack, backout, rsp_beta;
  logic [1:0] pkt_ctx = '0, mode = '0;
  logic [2:0] pkt_spd = '0;
  logic [6:0] pkt_flags = '0;
  logic [32:0] exp_q[$], mask_q[$], m, got, exp_v;
  localparam logic [32:0] FULL = 33'h1_FFFF_FFFF;
  localparam logic [32:0] NOST = 33'h1_FFFF_FD00;
  int n_fail = 0, tests_run = 0, cyc = 0, seed, c;
  logic b, d;
  logic [6:0] f;
  logic [6:0] tbl[7] = '{7'h00, 7'h40, 7'h20, 7'h08, 7'h10, 7'h48, 7'h04};

  iso_rx_ctrl i_iso_rx_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .fetch_req(fetch_req),
    .fetch_ack(fetch_ack), .fetch_valid(fetch_valid), .fetch_err(fetch_err),
    .pkt_valid(pkt_valid), .pkt_ctx(pkt_ctx), .pkt_beta(pkt_beta), .pkt_spd(pkt_spd),
    .pkt_len_err(pkt_flags[6]), .pkt_crc_err(pkt_flags[5]), .pkt_overrun(pkt_flags[4]),
    .pkt_long(pkt_flags[3]), .pkt_wr_err(pkt_flags[2]), .pkt_unknown(pkt_flags[1]),
    .pkt_buf_full(pkt_flags[0]), .backout(backout), .rsp_beta(rsp_beta));
  rx_partner i_rx_partner (.clk_sys(clk_sys), .mode(mode), .slow(slow),
    .fetch_req(fetch_req), .fetch_ack(fetch_ack), .fetch_valid(fetch_valid),
    .fetch_err(fetch_err));

  // 100 ns clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    $display("TB: counts fail=%0d run=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the expected few hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  // read results are checked against the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      m = mask_q.pop_front();
      got = {pslverr, prdata} & m;
      // pop once: the macro reads its second argument twice
      exp_v = exp_q.pop_front() & m;
      `CHK(got, exp_v)
    end
  end

  function automatic logic [11:0] ca(input int n, input logic clr);
    return CTX_SET_BASE + 12'(n) * CTX_STRIDE + (clr ? 12'h004 : 12'h000);
  endfunction

  // control word: fill, run, wake, dead, active, beta, speed, event
  function automatic logic [32:0] cw(input logic fl, r, k, dd, a, bb,
                                     input logic [2:0] s, input logic [4:0] e);
    return {1'b0, fl, 15'h0, r, 2'b0, k, dd, a, bb, 1'b0, s, e};
  endfunction

  function automatic logic [4:0] ev(input logic fl, input logic [6:0] ff);
    if (ff[2]) return EVT_DATA_WRITE;
    if (ff[1]) return EVT_UNKNOWN;
    if (fl) return ACK_COMPLETE;
    if (ff[4]) return EVT_OVERRUN;
    if (ff[3]) return EVT_LONG_PACKET;
    if (ff[6] | ff[5]) return ACK_DATA_ERROR;
    return ACK_COMPLETE;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] mk);
    exp_q.push_back(e);
    mask_q.push_back(mk);
    apb(1'b0, a, 32'h0);
  endtask

  // one packet report; qualifiers inverted once it is gone
  task automatic pkt(input logic bb, input logic [2:0] s, input logic [6:0] ff);
    @(posedge clk_sys);
    pkt_valid <= 1'b1;
    pkt_ctx <= 2'(c);
    pkt_beta <= bb;
    pkt_spd <= s;
    pkt_flags <= ff;
    @(posedge clk_sys);
    pkt_valid <= 1'b0;
    pkt_beta <= ~bb;
    pkt_spd <= ~s;
    pkt_flags <= ~ff;
  endtask

  // let a fetch start and be answered
  task automatic settle;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 50 && fetch_req[c] !== 1'b0; i++) @(negedge clk_sys);
  endtask

  initial begin
    seed = 38028;
    c = $unsigned($random(seed)) % 4;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      rd(ca(n, 0), 33'h0, FULL);
      rd(ca(n, 1), 33'h0, FULL);
    end
    rd(12'h010, {1'b1, 32'h0}, FULL);
    // run with wake; the fetch consumes wake
    apb(1'b1, ca(c, 0), 32'h0000_9000);
    settle();
    rd(ca(c, 1), cw(0, 1, 0, 0, 1, 0, 3'h0, 5'h0), FULL);
    // packet per buffer: five of the seven event codes, every speed, dead last
    for (int k = 0; k < 7; k++) begin
      f = tbl[k];
      b = 1'($random(seed));
      d = f[2];
      pkt(b, 3'(k % 4), f);
      if (!d) settle();
      rd(ca(c, 0), cw(0, 1, 0, d, !d, b, 3'(k % 4), ev(0, f)), FULL);
      `CHK(rsp_beta[c], b)
    end
    apb(1'b1, ca(c, 1), 32'h0000_8000);
    // last packet of the loop carried speed code 2
    rd(ca(c, 0), cw(0, 0, 0, 0, 0, b, 3'h2, EVT_DATA_WRITE), FULL);
    // interrupts masked, enabled, cleared
    rd(INT_STATUS_ADDR, 33'(12'h101 << c), FULL);
    @(negedge clk_sys);
    `CHK(irq, 1'b0)
    apb(1'b1, INT_ENABLE_ADDR, 32'h0000_0FFF);
    rd(INT_ENABLE_ADDR, 33'h0_0000_0FFF, FULL);
    @(negedge clk_sys);
    `CHK(irq, 1'b1)
    apb(1'b1, INT_CLEAR_ADDR, 32'h0000_0FFF);
    rd(INT_STATUS_ADDR, 33'h0, FULL);
    `CHK(irq, 1'b0)
    // fill mode: set while stopped, refused while running
    apb(1'b1, ca(c, 0), 32'h8000_0000);
    apb(1'b1, ca(c, 0), 32'h0000_8000);
    settle();
    apb(1'b1, ca(c, 1), 32'h8000_0000);
    pkt(b, 3'h3, 7'h08);
    repeat (3) @(negedge clk_sys);
    `CHK(fetch_req[c], 1'b0)
    rd(ca(c, 0), cw(1, 1, 0, 0, 1, b, 3'h3, ACK_COMPLETE), FULL);
    for (int j = 0; j < 3; j++) begin
      pkt(~b, 3'h1, 7'h40 >> j);
      @(negedge clk_sys);
      `CHK(backout[c], 1'b1)
      rd(ca(c, 0), cw(1, 1, 0, 0, 1, b, 3'h3, ACK_COMPLETE), FULL);
    end
    pkt(1'b0, 3'h2, 7'h01);
    settle();
    pkt(1'b0, 3'h0, 7'h02);
    @(negedge clk_sys);
    rd(ca(c, 0), cw(1, 1, 0, 1, 0, 0, 3'h0, EVT_UNKNOWN), FULL);
    rd(INT_STATUS_ADDR, 33'(12'h111 << c), FULL);
    `CHK(irq, 1'b1)
    apb(1'b1, ca(c, 1), 32'h0000_8000);
    // descriptor read error is fatal
    mode <= 2'h1;
    apb(1'b1, ca(c, 0), 32'h0000_8000);
    settle();
    rd(ca(c, 0), cw(1, 1, 0, 1, 0, 0, 3'h0, EVT_DESC_READ), FULL);
    apb(1'b1, ca(c, 1), 32'h0000_8000);
    // no descriptor: stall until wake, slow partner; event code left alone
    mode <= 2'h2;
    slow <= 1'b1;
    apb(1'b1, ca(c, 0), 32'h0000_8000);
    settle();
    rd(ca(c, 0), cw(1, 1, 0, 0, 0, 0, 3'h0, EVT_DESC_READ), FULL & ~33'h400);
    mode <= 2'h0;
    apb(1'b1, ca(c, 0), 32'h0000_1000);
    settle();
    rd(ca(c, 0), cw(1, 1, 0, 0, 1, 0, 3'h0, EVT_DESC_READ), FULL);
    repeat (4) @(posedge clk_sys);
    close_out();
  end
endmodule
